//--- verilog/dffm_params.svh
// constants of the drive fault flag masking block
`ifndef DFFM_PARAMS_SVH
`define DFFM_PARAMS_SVH
// object indices and subindices
`define DFFM_IDX_FLAGS     16'h2320
`define DFFM_IDX_MASKS     16'h2321
`define DFFM_IDX_HANDLE    16'h2322
`define DFFM_SUB_COUNT     8'h00
`define DFFM_SUB_1         8'h01
`define DFFM_SUB_2         8'h02
`define DFFM_SUB_3         8'h03
`define DFFM_MASK_COUNT    8'h03
`define DFFM_HANDLE_COUNT  8'h02
// reset values
`define DFFM_EMCY_MASK_RST 16'hFFFF
`define DFFM_SHUT_MASK_RST 16'h0000
`define DFFM_PIN_MASK_RST  16'h00FF
`define DFFM_DELAY_RST     16'h00C8
`define DFFM_DEV_RST       16'h7530
// fault flag bit positions
`define DFFM_B_OCUR   0
`define DFFM_B_DEV    1
`define DFFM_B_OVOLT  2
`define DFFM_B_OTEMP  3
`define DFFM_B_MEM    4
`define DFFM_B_PASSV  6
`define DFFM_B_OVRN   7
`define DFFM_B_GUARD  8
`define DFFM_B_BOFF   9
`define DFFM_B_OFLOW  11
`define DFFM_B_SWERR  12
`define DFFM_B_PLONG  13
`define DFFM_B_PSHORT 14
// flags cleared by a drive fault reset; link flags never are
`define DFFM_RESETTABLE 16'h7810
`define DFFM_COMM_BITS  16'h03C0
// emergency codes per flag
`define DFFM_C_RESET  16'h0000
`define DFFM_C_OCUR   16'h2310
`define DFFM_C_DEV    16'h8400
`define DFFM_C_OVOLT  16'h3210
`define DFFM_C_OTEMP  16'h4310
`define DFFM_C_MEM    16'h5530
`define DFFM_C_PASSV  16'h8120
`define DFFM_C_OVRN   16'h8110
`define DFFM_C_GUARD  16'h8130
`define DFFM_C_BOFF   16'h8140
`define DFFM_C_OFLOW  16'h6320
`define DFFM_C_SWERR  16'h6100
`define DFFM_C_PLONG  16'h8210
`define DFFM_C_PSHORT 16'h8220
// standard error register bits
`define DFFM_STD_GENERIC 0
`define DFFM_STD_COMM    4
// timing
`define DFFM_CLK_NS       10
`define DFFM_TICK_NS      10000000
`define DFFM_OVR_DELAY_NS 1000
`endif

//--- verilog/dffm_pkg.sv
// types of the drive fault flag masking block
package dffm_pkg;
  // object dictionary request
  typedef struct packed {
    logic        valid;
    logic        wr;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [15:0] wdata;
  } dffm_od_req_t;
  // object dictionary answer
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } dffm_od_rsp_t;
  // emergency telegram offered to the can transmitter
  typedef struct packed {
    logic        valid;
    logic [15:0] code;
    logic [7:0]  errreg;
  } dffm_emcy_t;
endpackage

//--- verilog/dffm_persist.sv
// persistence filter: condition must hold for delay ticks
`timescale 1ns/10ps
module dffm_persist (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  // condition and timebase
  input  wire logic        cond_in,
  input  wire logic        tick_in,
  input  wire logic [15:0] delay_in,
  // filtered fault
  output logic             fault_out
);
  logic [15:0] cnt_q;

  // count hundredths while the condition stands, restart on drop
  always_ff @(posedge core_clk_in) begin
    if (srst_in || !cond_in) begin
      cnt_q <= 16'h0000;
    end else if (tick_in && cnt_q < delay_in) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // report only once the full delay has elapsed
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      fault_out <= 1'b0;
    end else begin
      fault_out <= cond_in && (cnt_q >= delay_in);
    end
  end
endmodule // dffm_persist

//--- verilog/dffm_top.sv
// fault flag register, masks and emergency queue of a motor drive
`timescale 1ns/10ps
`include "dffm_params.svh"

// Operation
// RL1 - input overrun queues code 8110, sets comm bit 4 and flag bit 7
// RL2 - overrun telegram goes out delayed; error-reset telegram keeps bits set
// RL3 - error-passive entry sends 8120, sets comm bit 4 and flag bit 6
// RL4 - return to error-active sends error-reset code, clears flag bit 6
// RL5 - valid frame while bus-off sends 8140, sets bit 4 and bit 9
// RL6 - overrun, bus-off recovery and monitoring flags stick until restart
// RL7 - read-only 16-bit fault flag register, one bit per error type
// RL8 - bits 0..4: overcurrent, deviation, overvoltage, overtemperature, memory
// RL9 - bits 6..9: error passive, overrun, monitoring error, bus-off recovery
// RL10 - bit 11 computation overflow, bit 12 internal software error
// RL11 - long frame sets bit 13 and is processed; short sets 14, dropped
// RL12 - every flag bit maps to its own emergency code
// RL13 - only bits enabled in emergency mask send telegrams; resets all ones
// RL14 - bits in shutdown mask drive fault reaction; mask resets to zero
// RL15 - bits in pin mask assert error pin; mask resets to 00FF
// RL16 - writing shutdown mask also sets those bits in emergency mask
// RL17 - overcurrent, deviation, overvoltage must persist delay hundredths
// RL18 - deviation: absolute speed difference above limit for the delay
// RL19 - entry counts read 3 for masks and 2 for handling object
// RL20 - guarding or heartbeat timeout sets bit 8 and sends 8130
// RL21 - telegram sent once when an enabled bit newly sets
module dffm_top #(
  parameter int TICK_CYCLES = `DFFM_TICK_NS / `DFFM_CLK_NS
) (
  // clock and reset
  input  wire logic                 core_clk_in,
  input  wire logic                 srst_in,
  // object dictionary access
  input  wire dffm_pkg::dffm_od_req_t od_req_in,
  output dffm_pkg::dffm_od_rsp_t    od_rsp_out,
  // can controller events
  input  wire logic                 can_overrun_in,
  input  wire logic                 can_passive_in,
  input  wire logic                 can_busoff_in,
  input  wire logic                 can_rx_valid_in,
  input  wire logic                 guard_timeout_in,
  input  wire logic                 hb_timeout_in,
  // process data frames
  input  wire logic                 pdo_rx_in,
  input  wire logic [3:0]           pdo_len_in,
  input  wire logic [3:0]           pdo_exp_len_in,
  output logic                      pdo_process_out,
  // drive conditions
  input  wire logic                 ocur_in,
  input  wire logic                 ovolt_in,
  input  wire logic                 otemp_in,
  input  wire logic                 mem_err_in,
  input  wire logic                 calc_ovf_in,
  input  wire logic                 sw_err_in,
  input  wire logic signed [15:0]   act_vel_in,
  input  wire logic signed [15:0]   tgt_vel_in,
  input  wire logic                 fault_reset_in,
  // emergency telegram handshake
  output dffm_pkg::dffm_emcy_t      emcy_out,
  input  wire logic                 emcy_ready_in,
  // drive side outputs
  output logic                      shutdown_out,
  output logic                      fault_pin_out,
  output logic [7:0]                std_err_out
);
  localparam int OVR_CYC =
    (`DFFM_OVR_DELAY_NS + `DFFM_CLK_NS - 1) / `DFFM_CLK_NS;
  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic [15:0]   flags_q, flags_d, rise;
  logic [15:0]   emcy_mask_q, shut_mask_q, pin_mask_q;
  logic [15:0]   delay_q, dev_lim_q;
  logic [15:0]   pend_q, pend_d, elig;
  logic          rst_pend_q, rst_pend_d;
  logic          passive_q;
  logic [15:0]   ovr_cnt_q;
  logic [TW-1:0] tick_cnt_q;
  logic          tick;
  logic [2:0]    cond, filt;
  logic          pdo_long, pdo_short;
  logic          pin_hit, shut_hit;
  dffm_pkg::dffm_emcy_t emcy_d;

  // emergency code of each flag bit [RL12]
  function automatic logic [15:0] code_of(input logic [3:0] b);
    case (b)
      4'h0:    code_of = `DFFM_C_OCUR;
      4'h1:    code_of = `DFFM_C_DEV;
      4'h2:    code_of = `DFFM_C_OVOLT;
      4'h3:    code_of = `DFFM_C_OTEMP;
      4'h4:    code_of = `DFFM_C_MEM;
      4'h6:    code_of = `DFFM_C_PASSV;
      4'h7:    code_of = `DFFM_C_OVRN;
      4'h8:    code_of = `DFFM_C_GUARD;
      4'h9:    code_of = `DFFM_C_BOFF;
      4'hB:    code_of = `DFFM_C_OFLOW;
      4'hC:    code_of = `DFFM_C_SWERR;
      4'hD:    code_of = `DFFM_C_PLONG;
      default: code_of = `DFFM_C_PSHORT;
    endcase
  endfunction

  // lowest set bit index; ties resolved toward equipment faults
  function automatic logic [3:0] first_bit(input logic [15:0] v);
    first_bit = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) first_bit = 4'(i);
    end
  endfunction

  // absolute speed difference, one bit wider to avoid wrap
  function automatic logic [16:0] abs_diff(input logic signed [15:0] a,
                                           input logic signed [15:0] b);
    logic signed [16:0] d;
    d = 17'(a) - 17'(b);
    abs_diff = d[16] ? 17'(-d) : 17'(d);
  endfunction

  // hundredth-of-a-second timebase for the persistence filters
  always_ff @(posedge core_clk_in) begin
    if (srst_in || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end
  assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

  // raw conditions: overcurrent, deviation, overvoltage [RL18]
  assign cond[0] = ocur_in;
  assign cond[1] = abs_diff(act_vel_in, tgt_vel_in) > {1'b0, dev_lim_q};
  assign cond[2] = ovolt_in;

  // one filter per delayed fault [RL17]
  for (genvar g = 0; g < 3; g++) begin : g_persist
    dffm_persist u_persist (
      .core_clk_in (core_clk_in),
      .srst_in     (srst_in),
      .cond_in     (cond[g]),
      .tick_in     (tick),
      .delay_in    (delay_q),
      .fault_out   (filt[g])
    );
  end

  // frame length classification [RL11]
  assign pdo_long  = pdo_rx_in && (pdo_len_in > pdo_exp_len_in);
  assign pdo_short = pdo_rx_in && (pdo_len_in < pdo_exp_len_in);

  // next flag value; set terms come last so a set beats a clear
  always_comb begin
    flags_d = flags_q;
    if (fault_reset_in) begin
      flags_d = flags_q & ~`DFFM_RESETTABLE;
    end
    flags_d[`DFFM_B_OCUR]  = filt[0];                         // [RL8]
    flags_d[`DFFM_B_DEV]   = filt[1];                         // [RL8]
    flags_d[`DFFM_B_OVOLT] = filt[2];                         // [RL8]
    flags_d[`DFFM_B_OTEMP] = otemp_in;                        // [RL8]
    if (mem_err_in) flags_d[`DFFM_B_MEM] = 1'b1;              // [RL8]
    flags_d[`DFFM_B_PASSV] = can_passive_in;              // [RL3] [RL4]
    if (can_overrun_in) flags_d[`DFFM_B_OVRN] = 1'b1;         // [RL1] [RL9]
    if (guard_timeout_in || hb_timeout_in) begin
      flags_d[`DFFM_B_GUARD] = 1'b1;                          // [RL20]
    end
    if (can_rx_valid_in && can_busoff_in) begin
      flags_d[`DFFM_B_BOFF] = 1'b1;                           // [RL5]
    end
    if (calc_ovf_in) flags_d[`DFFM_B_OFLOW] = 1'b1;           // [RL10]
    if (sw_err_in)   flags_d[`DFFM_B_SWERR] = 1'b1;           // [RL10]
    if (pdo_long)    flags_d[`DFFM_B_PLONG] = 1'b1;           // [RL11]
    if (pdo_short)   flags_d[`DFFM_B_PSHORT] = 1'b1;          // [RL11]
  end

  // link flags 7..9 only ever set, so only srst clears them [RL6]
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      flags_q <= 16'h0000;
    end else begin
      flags_q <= flags_d;                                     // [RL7]
    end
  end
  assign rise = flags_d & ~flags_q;

  // process short-free frames one cycle after arrival [RL11]
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pdo_process_out <= 1'b0;
    end else begin
      pdo_process_out <= pdo_rx_in && !pdo_short;
    end
  end

  // passive level history for the return-to-active edge
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      passive_q <= 1'b0;
    end else begin
      passive_q <= can_passive_in;
    end
  end

  // overrun telegram hold-off, loaded only when the overrun flag first sets [RL2]
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ovr_cnt_q <= 16'h0000;
    end else if (rise[`DFFM_B_OVRN]) begin
      ovr_cnt_q <= 16'(OVR_CYC);
    end else if (ovr_cnt_q != 16'h0000) begin
      ovr_cnt_q <= ovr_cnt_q - 16'h0001;
    end
  end
  assign elig = pend_q & ~((ovr_cnt_q != 16'h0000) ?
                           (16'h0001 << `DFFM_B_OVRN) : 16'h0000);

  // telegram queue: one per newly set enabled bit [RL21]
  always_comb begin
    pend_d     = pend_q;
    rst_pend_d = rst_pend_q;
    emcy_d     = emcy_out;
    if (!emcy_out.valid || emcy_ready_in) begin
      emcy_d.valid = 1'b0;
      if (elig != 16'h0000) begin
        emcy_d.valid = 1'b1;
        emcy_d.code  = code_of(first_bit(elig));              // [RL12]
        emcy_d.errreg = std_err_out;
        pend_d[first_bit(elig)] = 1'b0;
      end else if (rst_pend_q) begin
        emcy_d.valid = 1'b1;
        emcy_d.code  = `DFFM_C_RESET;                          // [RL4]
        emcy_d.errreg = std_err_out;
        rst_pend_d   = 1'b0;
      end
    end
    // errreg is frozen with the code so a held telegram never changes
    pend_d = pend_d | (rise & emcy_mask_q);                   // [RL13]
    if (passive_q && !can_passive_in) begin
      rst_pend_d = 1'b1;                                      // [RL4]
    end
  end

  // queue and telegram registers
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pend_q     <= 16'h0000;
      rst_pend_q <= 1'b0;
      emcy_out   <= '0;
    end else begin
      pend_q     <= pend_d;
      rst_pend_q <= rst_pend_d;
      emcy_out   <= emcy_d;
    end
  end

  // standard error register: generic plus communication [RL1] [RL3]
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      std_err_out <= 8'h00;
    end else begin
      std_err_out <= 8'h00;
      std_err_out[`DFFM_STD_GENERIC] <= |flags_d;
      std_err_out[`DFFM_STD_COMM] <= |(flags_d & `DFFM_COMM_BITS);
    end
  end

  // shutdown and pin outputs; a zero mask never asserts them
  assign shut_hit = |(flags_q & shut_mask_q);
  assign pin_hit  = |(flags_q & pin_mask_q);
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      shutdown_out  <= 1'b0;
      fault_pin_out <= 1'b0;
    end else begin
      shutdown_out  <= shut_hit;                              // [RL14]
      fault_pin_out <= pin_hit;                               // [RL15]
    end
  end

  // writable objects; shutdown bits also land in the emergency mask
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      emcy_mask_q <= `DFFM_EMCY_MASK_RST;                     // [RL13]
      shut_mask_q <= `DFFM_SHUT_MASK_RST;                     // [RL14]
      pin_mask_q  <= `DFFM_PIN_MASK_RST;                      // [RL15]
      delay_q     <= `DFFM_DELAY_RST;                         // [RL17]
      dev_lim_q   <= `DFFM_DEV_RST;                           // [RL18]
    end else if (od_req_in.valid && od_req_in.wr) begin
      if (od_req_in.index == `DFFM_IDX_MASKS) begin
        if (od_req_in.sub == `DFFM_SUB_1) begin
          emcy_mask_q <= od_req_in.wdata;
        end else if (od_req_in.sub == `DFFM_SUB_2) begin
          shut_mask_q <= od_req_in.wdata;
          emcy_mask_q <= emcy_mask_q | od_req_in.wdata;       // [RL16]
        end else if (od_req_in.sub == `DFFM_SUB_3) begin
          pin_mask_q  <= od_req_in.wdata;
        end
      end else if (od_req_in.index == `DFFM_IDX_HANDLE) begin
        if (od_req_in.sub == `DFFM_SUB_1) begin
          delay_q   <= od_req_in.wdata;
        end else if (od_req_in.sub == `DFFM_SUB_2) begin
          dev_lim_q <= od_req_in.wdata;
        end
      end
    end
  end

  // read data and abort flag, answered one cycle after the request
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      od_rsp_out <= '0;
    end else begin
      od_rsp_out       <= '0;
      od_rsp_out.ack   <= od_req_in.valid;
      od_rsp_out.err   <= od_req_in.valid;
      if (!od_req_in.valid) begin
        od_rsp_out.err <= 1'b0;
      end else if (od_req_in.index == `DFFM_IDX_FLAGS &&
                   od_req_in.sub == `DFFM_SUB_COUNT) begin
        od_rsp_out.err   <= od_req_in.wr;                     // [RL7]
        od_rsp_out.rdata <= flags_q;
      end else if (od_req_in.index == `DFFM_IDX_MASKS) begin
        od_rsp_out.err <= 1'b0;
        if (od_req_in.sub == `DFFM_SUB_COUNT) begin
          od_rsp_out.err   <= od_req_in.wr;
          od_rsp_out.rdata <= {8'h00, `DFFM_MASK_COUNT};      // [RL19]
        end else if (od_req_in.sub == `DFFM_SUB_1) begin
          od_rsp_out.rdata <= emcy_mask_q;
        end else if (od_req_in.sub == `DFFM_SUB_2) begin
          od_rsp_out.rdata <= shut_mask_q;
        end else if (od_req_in.sub == `DFFM_SUB_3) begin
          od_rsp_out.rdata <= pin_mask_q;
        end else begin
          od_rsp_out.err <= 1'b1;
        end
      end else if (od_req_in.index == `DFFM_IDX_HANDLE) begin
        od_rsp_out.err <= 1'b0;
        if (od_req_in.sub == `DFFM_SUB_COUNT) begin
          od_rsp_out.err   <= od_req_in.wr;
          od_rsp_out.rdata <= {8'h00, `DFFM_HANDLE_COUNT};    // [RL19]
        end else if (od_req_in.sub == `DFFM_SUB_1) begin
          od_rsp_out.rdata <= delay_q;
        end else if (od_req_in.sub == `DFFM_SUB_2) begin
          od_rsp_out.rdata <= dev_lim_q;
        end else begin
          od_rsp_out.err <= 1'b1;
        end
      end
    end
  end

  // checks on the block's own outputs and internal registers
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  property p_ovr_sticky;
    flags_q[`DFFM_B_OVRN] |=> flags_q[`DFFM_B_OVRN];
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky) // [RL6]
    else $error("overrun flag dropped");

  property p_busoff_set;
    can_rx_valid_in && can_busoff_in |=>
      flags_q[`DFFM_B_BOFF] ##1 std_err_out[`DFFM_STD_COMM];
  endproperty
  a_busoff_set: assert property (p_busoff_set) // [RL5]
    else $error("bus-off recovery not flagged");

  property p_passive_clear;
    passive_q && !can_passive_in |=> !flags_q[`DFFM_B_PASSV]
      ##[1:40] (emcy_out.valid && emcy_out.code == `DFFM_C_RESET);
  endproperty
  a_passive_clear: assert property (p_passive_clear) // [RL4]
    else $error("no error reset after return to active");

  property p_pin;
    pin_hit |=> fault_pin_out;
  endproperty
  a_pin: assert property (p_pin) // [RL15]
    else $error("error pin not asserted");

  property p_shut_copy;
    od_req_in.valid && od_req_in.wr &&
    od_req_in.index == `DFFM_IDX_MASKS && od_req_in.sub == `DFFM_SUB_2
    |=> ((emcy_mask_q & shut_mask_q) == shut_mask_q);
  endproperty
  a_shut_copy: assert property (p_shut_copy) // [RL16]
    else $error("shutdown bits missing in emergency mask");

  property p_mask_gate;
    (pend_q & ~$past(pend_q) & ~$past(emcy_mask_q)) == 16'h0000;
  endproperty
  a_mask_gate: assert property (p_mask_gate) // [RL13]
    else $error("masked error queued a telegram");

  property p_short_drop;
    pdo_short |=> !pdo_process_out && flags_q[`DFFM_B_PSHORT];
  endproperty
  a_short_drop: assert property (p_short_drop) // [RL11]
    else $error("short frame processed or not flagged");

  property p_ovr_wait;
    rise[`DFFM_B_OVRN] |=>
      !(emcy_out.valid && emcy_out.code == `DFFM_C_OVRN) [*8];
  endproperty
  a_ovr_wait: assert property (p_ovr_wait) // [RL2]
    else $error("overrun telegram not delayed");

  property p_count_ro;
    od_req_in.valid && !od_req_in.wr &&
    od_req_in.index == `DFFM_IDX_MASKS &&
    od_req_in.sub == `DFFM_SUB_COUNT |=> od_rsp_out.rdata == 16'h0003;
  endproperty
  a_count_ro: assert property (p_count_ro) // [RL19]
    else $error("mask entry count wrong");

  c_emcy_sent: cover property (emcy_out.valid && emcy_ready_in);
  c_shutdown:  cover property ($rose(shutdown_out));
  c_pin:       cover property ($rose(fault_pin_out));
endmodule // dffm_top

//--- verification/dffm_far_end.sv
// network master model: takes emergency telegrams and logs their codes
`timescale 1ns/10ps
module dffm_far_end (
  // clock and reset
  input  wire logic                 core_clk_in,
  input  wire logic                 srst_in,
  // telegram channel
  input  wire dffm_pkg::dffm_emcy_t emcy_in,
  input  wire logic                 stall_in,
  output logic                      ready_out
);
  logic [15:0] log_q [0:63];
  int          n_q;

  // transmitter busy on command, so held telegrams can be observed
  assign ready_out = !stall_in;

  // log every code taken; index wraps, bench stays below 64 telegrams
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      n_q <= 0;
    end else if (emcy_in.valid && ready_out) begin
      log_q[n_q[5:0]] <= emcy_in.code;
      n_q             <= n_q + 1;
    end
  end
endmodule // dffm_far_end

//--- verification/dffm_top_tb.sv
// self-checking bench of the fault flag masking block
`timescale 1ns/10ps
`define CHK(w, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", w, e, g); end end
module dffm_top_tb;
  logic                    clk = 1'b0;
  logic                    srst = 1'b1;
  dffm_pkg::dffm_od_req_t  req;
  dffm_pkg::dffm_od_rsp_t  rsp;
  dffm_pkg::dffm_emcy_t    emcy;
  logic                    ovr, pas, bof, rxv, grd, hbt, pdo, proc;
  logic                    ocur, ovolt, otemp, mem, ovf, swe, frst;
  logic                    rdy, stall, shut, pin;
  logic [3:0]              len, elen;
  logic signed [15:0]      act, tgt;
  logic [7:0]              stderr;
  logic [15:0]             d;
  logic                    e;
  int                      n_fail = 0;
  int                      checked = 0;
  int                      n_proc = 0;

  // short tick keeps the persistence filter within a brief run
  dffm_top #(.TICK_CYCLES(10)) dut (
    .core_clk_in(clk), .srst_in(srst), .od_req_in(req), .od_rsp_out(rsp),
    .can_overrun_in(ovr), .can_passive_in(pas), .can_busoff_in(bof),
    .can_rx_valid_in(rxv), .guard_timeout_in(grd), .hb_timeout_in(hbt),
    .pdo_rx_in(pdo), .pdo_len_in(len), .pdo_exp_len_in(elen),
    .pdo_process_out(proc), .ocur_in(ocur), .ovolt_in(ovolt),
    .otemp_in(otemp), .mem_err_in(mem), .calc_ovf_in(ovf),
    .sw_err_in(swe), .act_vel_in(act), .tgt_vel_in(tgt),
    .fault_reset_in(frst), .emcy_out(emcy), .emcy_ready_in(rdy),
    .shutdown_out(shut), .fault_pin_out(pin), .std_err_out(stderr));
  dffm_far_end far (.core_clk_in(clk), .srst_in(srst), .emcy_in(emcy),
    .stall_in(stall), .ready_out(rdy));

  // clock and frame counter
  always #5 clk = ~clk;
  // counted mid-cycle, away from the edge that launches the pulse
  always @(negedge clk) if (proc === 1'b1) n_proc++;

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one object access; answer stands exactly one cycle after the pulse
  task automatic acc(input logic w, input logic [15:0] ix,
                     input logic [7:0] sb, input logic [15:0] wd);
    req = '{1'b1, w, ix, sb, wd};
    step(1);
    `CHK("ack", 1'b1, rsp.ack)
    d = rsp.rdata;
    e = rsp.err;
    req.valid = 1'b0;
    step(1);
  endtask
  task automatic rchk(input logic [15:0] ix, input logic [7:0] sb,
                      input logic [15:0] ex);
    acc(1'b0, ix, sb, 16'h0000);
    `CHK($sformatf("obj %h.%h", ix, sb), ex, d)
    `CHK("read err", 1'b0, e)
  endtask
  task automatic wchk(input logic [15:0] ix, input logic [7:0] sb,
                      input logic [15:0] wd);
    acc(1'b1, ix, sb, wd);
    `CHK("write err", 1'b0, e)
  endtask
  function automatic int cnt(input logic [15:0] c);
    int k;
    k = 0;
    for (int i = 0; i < far.n_q && i < 64; i++) if (far.log_q[i] === c) k++;
    return k;
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // watchdog well past the few hundred cycles the tests need
  initial begin
    #200000;
    n_fail++;
    $display("unexpected watchdog expiry");
    close_out;
  end

  // test sequence
  initial begin
    req = '0;
    {ovr, pas, bof, rxv, grd, hbt, pdo, ocur} = 8'h00;
    {ovolt, otemp, mem, ovf, swe, frst, stall} = 7'h00;
    len = 4'h8;
    elen = 4'h8;
    act = 16'sh0000;
    tgt = 16'sh0000;
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    rchk(16'h2321, 8'h00, 16'h0003);
    rchk(16'h2322, 8'h00, 16'h0002);
    rchk(16'h2321, 8'h01, 16'hFFFF);
    rchk(16'h2321, 8'h02, 16'h0000);
    rchk(16'h2321, 8'h03, 16'h00FF);
    rchk(16'h2322, 8'h01, 16'h00C8);
    rchk(16'h2322, 8'h02, 16'h7530);
    rchk(16'h2320, 8'h00, 16'h0000);
    acc(1'b1, 16'h2320, 8'h00, 16'hFFFF);
    `CHK("ro write", 1'b1, e)
    acc(1'b1, 16'h2321, 8'h00, 16'h0005);
    `CHK("count write", 1'b1, e)
    acc(1'b0, 16'h2321, 8'h04, 16'h0000);
    `CHK("bad sub", 1'b1, e)
    $display("test reset values done");
    // passive entry while transmitter stalls: telegram must stand
    stall = 1'b1;
    pas = 1'b1;
    step(4);
    `CHK("emcy code", 16'h8120, emcy.code)
    `CHK("emcy errreg", 8'h11, emcy.errreg)
    `CHK("std err", 8'h11, stderr)
    rchk(16'h2320, 8'h00, 16'h0040);
    `CHK("emcy held", 1'b1, emcy.valid)
    stall = 1'b0;
    step(2);
    pas = 1'b0;
    step(6);
    `CHK("n 8120", 1, cnt(16'h8120))
    `CHK("n 0000", 1, cnt(16'h0000))
    rchk(16'h2320, 8'h00, 16'h0000);
    $display("test error passive done");
    ovr = 1'b1;
    step(1);
    ovr = 1'b0;
    step(3);
    rchk(16'h2320, 8'h00, 16'h0080);
    `CHK("8110 early", 0, cnt(16'h8110))
    step(120);
    `CHK("n 8110", 1, cnt(16'h8110))
    `CHK("std err", 8'h11, stderr)
    pas = 1'b1;
    step(4);
    pas = 1'b0;
    step(6);
    rchk(16'h2320, 8'h00, 16'h0080);
    bof = 1'b1;
    rxv = 1'b1;
    step(1);
    {rxv, bof, grd} = 3'h1;
    step(1);
    grd = 1'b0;
    step(4);
    `CHK("n 8140", 1, cnt(16'h8140))
    `CHK("n 8130", 1, cnt(16'h8130))
    hbt = 1'b1;
    step(1);
    hbt = 1'b0;
    step(4);
    `CHK("n 8130", 1, cnt(16'h8130))
    rchk(16'h2320, 8'h00, 16'h0380);
    $display("test link errors done");
    wchk(16'h2321, 8'h01, 16'h0000);
    ovf = 1'b1;
    step(1);
    ovf = 1'b0;
    step(4);
    rchk(16'h2320, 8'h00, 16'h0B80);
    `CHK("n 6320", 0, cnt(16'h6320))
    wchk(16'h2321, 8'h02, 16'h0010);
    rchk(16'h2321, 8'h01, 16'h0010);
    wchk(16'h2321, 8'h03, 16'h0010);
    step(2);
    `CHK("pin", 1'b0, pin)
    `CHK("shutdown", 1'b0, shut)
    {mem, swe} = 2'h3;
    step(1);
    {mem, swe} = 2'h0;
    step(4);
    `CHK("shutdown", 1'b1, shut)
    `CHK("pin", 1'b1, pin)
    `CHK("n 5530", 1, cnt(16'h5530))
    wchk(16'h2321, 8'h03, 16'h0000);
    step(2);
    `CHK("pin", 1'b0, pin)
    $display("test masks done");
    // long frame processed, short frame dropped
    pdo = 1'b1;
    len = 4'h9;
    step(1);
    pdo = 1'b0;
    step(3);
    `CHK("n proc", 1, n_proc)
    pdo = 1'b1;
    len = 4'h7;
    step(1);
    pdo = 1'b0;
    step(3);
    `CHK("n proc", 1, n_proc)
    rchk(16'h2320, 8'h00, 16'h7B90);
    frst = 1'b1;
    step(1);
    frst = 1'b0;
    step(3);
    rchk(16'h2320, 8'h00, 16'h0380);
    `CHK("shutdown", 1'b0, shut)
    $display("test frames and reset done");
    wchk(16'h2322, 8'h01, 16'h0002);
    {ocur, ovolt} = 2'h3;
    act = 16'sd20000;
    tgt = -16'sd20000;
    step(6);
    rchk(16'h2320, 8'h00, 16'h0380);
    step(40);
    rchk(16'h2320, 8'h00, 16'h0387);
    otemp = 1'b1;
    step(3);
    rchk(16'h2320, 8'h00, 16'h038F);
    {ocur, ovolt, otemp} = 3'h0;
    act = 16'sh0000;
    tgt = 16'sh0000;
    step(4);
    rchk(16'h2320, 8'h00, 16'h0380);
    `CHK("std err", 8'h11, stderr)
    $display("test delayed faults done");
    close_out;
  end
endmodule // dffm_top_tb
